//--- hdl/sif_ctl.sv
// Scan interface control and status registers with the front-end steering.
// Assumes an APB master on pclk and a sequencer/front end on the same clock.
module sif_ctl #(
  parameter int NUM_FLAGS = sif_pkg::NUM_FLAGS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sequencer events
  input wire logic seq_start_pulse,
  input wire logic sequencer_stop_signal,
  input wire logic test_cycle_done,
  input wire logic [3:0] upper_flag_set,
  input wire logic [3:0] frontend_output_bits,
  input wire logic [2:0] flag_source_select,
  // Sequencer analogue requests
  input wire logic seq_dac_on,
  input wire logic seq_comp_on,
  input wire logic seq_gnd_connect,
  input wire logic [1:0] seq_channel,
  input wire logic test_cycle_active,
  input wire logic test_channel_id,
  // Front end result
  input wire logic comp_raw,
  input wire logic test_result_strobe,
  // Control outputs
  output logic module_enable,
  output logic test_cycle_insert,
  output logic dac_power,
  output logic comp_power,
  output logic comp_result,
  output logic [1:0] comp_src_group,
  output logic [1:0] comp_src_index,
  output logic cap_ground_tied,
  output logic mid_voltage_on,
  output logic sample_hold_on,
  output logic excitation_on,
  output logic flag_irq
);

  initial begin
    if (NUM_FLAGS != sif_pkg::POS_FLAG_HI - sif_pkg::POS_FLAG_LO + 1) begin
      $error("sif_ctl: NUM_FLAGS must match the register layout");
    end
  end

  // ****************************************
  // Declarations
  // ****************************************
  logic [NUM_FLAGS-1:0] irq_en_reg;
  logic enable_reg;
  logic test_ins_reg;
  logic [15:0] ctl_two_reg;
  logic stop_prev_reg;
  logic [3:0] fe_prev_reg;
  logic [NUM_FLAGS-1:0] flag_set;
  logic setup;
  logic wr_access;
  logic hit_one;
  logic hit_two;
  logic lo_lane_wr;
  logic hi_lane_wr;
  logic [15:0] ctl_one_val;
  logic [31:0] rd_next;
  logic cond_bit;
  logic cond_now;
  logic cond_prev;
  logic cond_event;
  logic [1:0] tch_sel;
  logic [1:0] src_group_next;
  logic [1:0] src_index_next;

  sif_flag_if #(.N(NUM_FLAGS)) fbus ();

  sif_flag_bank #(.N(NUM_FLAGS)) u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .fb(fbus.bank)
  );

  // ****************************************
  // APB decode
  // ****************************************
  // Zero wait states: the answer is prepared during setup, so pready
  // is already high in the first access cycle.
  assign setup = psel & ~penable;
  assign wr_access = psel & penable & pwrite & pready;
  assign hit_one = paddr[7:0] == sif_pkg::ADDR_CTL_ONE && paddr[31:8] == 24'h00_0000;
  assign hit_two = paddr[7:0] == sif_pkg::ADDR_CTL_TWO && paddr[31:8] == 24'h00_0000;
  assign lo_lane_wr = wr_access & pstrb[0];
  assign hi_lane_wr = wr_access & pstrb[1];

  always_comb begin
    ctl_one_val = sif_pkg::CTL_ONE_RST;
    ctl_one_val[sif_pkg::POS_EN] = enable_reg;
    ctl_one_val[sif_pkg::POS_TEST_INS] = test_ins_reg;
    ctl_one_val[sif_pkg::POS_FLAG_HI:sif_pkg::POS_FLAG_LO] = fbus.flags;
    ctl_one_val[sif_pkg::POS_IE_HI:sif_pkg::POS_IE_LO] = irq_en_reg;
  end

  always_comb begin
    rd_next = 32'h0000_0000;
    if (hit_one) begin
      rd_next[15:0] = ctl_one_val;
    end else if (hit_two) begin
      rd_next[15:0] = ctl_two_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~(hit_one | hit_two);
      if (setup && !pwrite) begin
        prdata <= rd_next;
      end
    end
  end

  // ****************************************
  // Control register one
  // ****************************************
  // Seven-bit flag field straddles both lanes; it is written whole only when both
  // lanes are strobed, which keeps one write strobe into the flag bank.
  assign fbus.wr = hit_one & lo_lane_wr & hi_lane_wr;
  assign fbus.wdata = pwdata[sif_pkg::POS_FLAG_HI:sif_pkg::POS_FLAG_LO];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= 1'b0;
    end else if (hit_one && lo_lane_wr) begin
      enable_reg <= pwdata[sif_pkg::POS_EN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_reg <= '0;
    end else if (hit_one && hi_lane_wr) begin
      irq_en_reg <= pwdata[sif_pkg::POS_IE_HI:sif_pkg::POS_IE_LO];
    end
  end

  // A fresh software request beats the end of the previous test cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_ins_reg <= 1'b0;
    end else if (hit_one && lo_lane_wr) begin
      test_ins_reg <= pwdata[sif_pkg::POS_TEST_INS];
    end else if (test_cycle_done) begin
      test_ins_reg <= 1'b0;
    end
  end

  // ****************************************
  // Event detection
  // ****************************************
  // Source select: bits 2:1 pick the front-end bit, bit 0 picks
  // falling (1) or rising (0) transition.
  assign cond_bit = flag_source_select[0];
  assign cond_now = frontend_output_bits[flag_source_select[2:1]];
  assign cond_prev = fe_prev_reg[flag_source_select[2:1]];
  assign cond_event = cond_bit ? (cond_prev & ~cond_now) : (~cond_prev & cond_now);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_prev_reg <= 1'b0;
      fe_prev_reg <= 4'h0;
    end else begin
      stop_prev_reg <= sequencer_stop_signal;
      fe_prev_reg <= frontend_output_bits;
    end
  end

  // Events count only while the interface runs
  always_comb begin
    flag_set = '0;
    flag_set[sif_pkg::FLAG_SEQ_START] = enable_reg & seq_start_pulse;
    flag_set[sif_pkg::FLAG_STOP_EDGE] =
      enable_reg & sequencer_stop_signal & ~stop_prev_reg;
    flag_set[sif_pkg::FLAG_OUT_COND] = enable_reg & cond_event;
    flag_set[NUM_FLAGS-1:sif_pkg::FLAG_SEQ_START+1] = {4{enable_reg}} & upper_flag_set;
  end
  assign fbus.set = flag_set;

  // ****************************************
  // Control register two
  // ****************************************
  // Front-end result bits are hardware-written on the strobe; hardware wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_two_reg <= sif_pkg::CTL_TWO_RST;
    end else begin
      if (hit_two && hi_lane_wr) begin
        ctl_two_reg[15:8] <= pwdata[15:8];
      end
      if (hit_two && lo_lane_wr) begin
        ctl_two_reg[7:0] <= pwdata[7:0];
      end
      if (test_result_strobe && test_channel_id) begin
        ctl_two_reg[sif_pkg::POS_TCH1_RES] <=
          comp_raw ^ ctl_two_reg[sif_pkg::POS_CMP_INV];
      end
      if (test_result_strobe && !test_channel_id) begin
        ctl_two_reg[sif_pkg::POS_TCH0_RES] <=
          comp_raw ^ ctl_two_reg[sif_pkg::POS_CMP_INV];
      end
    end
  end

  // ****************************************
  // Comparator source selection
  // ****************************************
  assign tch_sel = test_channel_id ?
    ctl_two_reg[sif_pkg::POS_TCH1_HI:sif_pkg::POS_TCH1_LO] :
    ctl_two_reg[sif_pkg::POS_TCH0_HI:sif_pkg::POS_TCH0_LO];

  always_comb begin
    src_group_next = sif_pkg::SIF_SRC_SENSOR;
    src_index_next = test_cycle_active ? tch_sel : seq_channel;
    if (ctl_two_reg[sif_pkg::POS_GROUP]) begin
      src_group_next = sif_pkg::SIF_SRC_AUX;
      if (ctl_two_reg[sif_pkg::POS_DEDICATED]) begin
        src_group_next = sif_pkg::SIF_SRC_COMMON;
        src_index_next = 2'h0;
      end else if (ctl_two_reg[sif_pkg::POS_AUX3] && !test_cycle_active) begin
        src_index_next = sif_pkg::AUX_THREE;
      end
    end
  end

  // ****************************************
  // Registered analogue controls
  // ****************************************
  // Disabled interface parks the power, bias and test-insert outputs off; the ground tie
  // stays in its safe tied state, and comparator result and source keep following.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_enable <= 1'b0;
      test_cycle_insert <= 1'b0;
    end else begin
      module_enable <= enable_reg;
      test_cycle_insert <= enable_reg & test_ins_reg;
    end
  end

  // Requests are ORed, so the sequencer cannot switch a forced unit off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_power <= 1'b0;
      comp_power <= 1'b0;
    end else begin
      dac_power <= enable_reg & (ctl_two_reg[sif_pkg::POS_DAC_ON] | seq_dac_on);
      comp_power <= enable_reg & (ctl_two_reg[sif_pkg::POS_CMP_ON] | seq_comp_on);
    end
  end

  // Not gated, so software can still watch the comparator while disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_result <= 1'b0;
    end else begin
      comp_result <= comp_raw ^ ctl_two_reg[sif_pkg::POS_CMP_INV];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_src_group <= sif_pkg::SIF_SRC_SENSOR;
      comp_src_index <= 2'h0;
    end else begin
      comp_src_group <= src_group_next;
      comp_src_index <= src_index_next;
    end
  end

  // Resets high: an untied sample capacitor would float
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_ground_tied <= 1'b1;
    end else begin
      cap_ground_tied <= ~ctl_two_reg[sif_pkg::POS_GND_SEL] | ~enable_reg
        | seq_gnd_connect;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mid_voltage_on <= 1'b0;
      sample_hold_on <= 1'b0;
      excitation_on <= 1'b0;
    end else begin
      mid_voltage_on <= enable_reg & ctl_two_reg[sif_pkg::POS_MID_V]
        & ~ctl_two_reg[sif_pkg::POS_SH];
      sample_hold_on <= enable_reg & ctl_two_reg[sif_pkg::POS_SH];
      excitation_on <= enable_reg & ctl_two_reg[sif_pkg::POS_EXC];
    end
  end

  // Lags the flag by one edge; flags themselves are already registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_irq <= 1'b0;
    end else begin
      flag_irq <= |(fbus.flags & irq_en_reg);
    end
  end

endmodule // sif_ctl

//--- hdl/sif_pkg.sv
// Constants shared by the scan interface control block and its flag bank.
// Assumes a 32-bit APB register bus; registers hold 16 bits in the low lanes.
package sif_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_CTL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CTL_TWO = 8'h04;
  localparam int REG_W = 16;
  localparam logic [15:0] CTL_ONE_RST = 16'h0000;
  localparam logic [15:0] CTL_TWO_RST = 16'h0000;

  // ****************************************
  // Control register one fields
  // ****************************************
  localparam int NUM_FLAGS = 7;
  localparam int POS_EN = 0;
  localparam int POS_TEST_INS = 1;
  localparam int POS_FLAG_LO = 2;
  localparam int POS_FLAG_HI = 8;
  localparam int POS_IE_LO = 9;
  localparam int POS_IE_HI = 15;
  localparam int FLAG_OUT_COND = 0;
  localparam int FLAG_STOP_EDGE = 1;
  localparam int FLAG_SEQ_START = 2;

  // ****************************************
  // Control register two fields
  // ****************************************
  localparam int POS_DAC_ON = 15;
  localparam int POS_CMP_ON = 14;
  localparam int POS_CMP_INV = 13;
  localparam int POS_GROUP = 12;
  localparam int POS_DEDICATED = 11;
  localparam int POS_AUX3 = 10;
  localparam int POS_GND_SEL = 9;
  localparam int POS_MID_V = 8;
  localparam int POS_SH = 7;
  localparam int POS_EXC = 6;
  localparam int POS_TCH1_HI = 5;
  localparam int POS_TCH1_LO = 4;
  localparam int POS_TCH0_HI = 3;
  localparam int POS_TCH0_LO = 2;
  localparam int POS_TCH1_RES = 1;
  localparam int POS_TCH0_RES = 0;
  localparam logic [1:0] AUX_THREE = 2'h3;

  // Comparator source groups
  typedef enum logic [1:0] {
    SIF_SRC_SENSOR,
    SIF_SRC_AUX,
    SIF_SRC_COMMON
  } sif_src_e;

endpackage

//--- hdl/sif_flag_if.sv
// Carrier between the control register block and the sticky flag bank.
// Assumes both ends share pclk.
interface sif_flag_if #(parameter int N = 7);
  logic [N-1:0] set;
  logic wr;
  logic [N-1:0] wdata;
  logic [N-1:0] flags;
  modport ctl (output set, output wr, output wdata, input flags);
  modport bank (input set, input wr, input wdata, output flags);
endinterface

//--- hdl/sif_flag_bank.sv
// Bank of sticky event flags, written directly by software.
// Assumes set pulses and write strobes are synchronous to pclk.
module sif_flag_bank #(
  parameter int N = 7
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Flag carrier
  sif_flag_if.bank fb
);

  initial begin
    if (N < 1 || N > 16) begin
      $error("sif_flag_bank: N out of range");
    end
  end

  // ****************************************
  // Per-flag storage
  // ****************************************
  // Set beats a same-cycle software clear so no event is lost
  for (genvar i = 0; i < N; i++) begin : g_flag
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        fb.flags[i] <= 1'b0;
      end else if (fb.set[i]) begin
        fb.flags[i] <= 1'b1;
      end else if (fb.wr) begin
        fb.flags[i] <= fb.wdata[i];
      end
    end
  end

endmodule // sif_flag_bank

//--- verif/sif_ctl_asserts.sv
// Port-level checker for the scan interface control block.
// Assumes one pclk domain and outputs registered one edge after their cause.
module sif_ctl_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Sequencer requests
  input wire logic seq_dac_on,
  input wire logic seq_comp_on,
  input wire logic seq_gnd_connect,
  // Control outputs
  input wire logic module_enable,
  input wire logic test_cycle_insert,
  input wire logic dac_power,
  input wire logic comp_power,
  input wire logic cap_ground_tied,
  input wire logic mid_voltage_on,
  input wire logic sample_hold_on,
  input wire logic excitation_on
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************
  // Bus handshake
  // ****************************************
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    setup_s ##1 (psel && penable);
  endsequence
  ready_due_a: assert property (access_s |-> pready)
    else $error("no ready in access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  addr_err_a: assert property (access_s |-> pslverr == (paddr != 32'h0000_0000
      && paddr != 32'h0000_0004))
    else $error("error flag wrong for address");
  // ****************************************
  // Analogue steering
  // ****************************************
  // Enable and output registers load on the same edge, so compare in-cycle
  dac_follow_a: assert property (module_enable && $past(seq_dac_on) |-> dac_power)
    else $error("dac not under sequencer");
  cmp_follow_a: assert property (module_enable && $past(seq_comp_on) |-> comp_power)
    else $error("comparator not under sequencer");
  off_gated_a: assert property (!module_enable |-> !(dac_power || comp_power ||
      mid_voltage_on || sample_hold_on || excitation_on || test_cycle_insert))
    else $error("output active while disabled");
  mid_excl_a: assert property (mid_voltage_on |-> !sample_hold_on)
    else $error("mid voltage with sample hold");
  gnd_tied_a: assert property (!module_enable || $past(seq_gnd_connect)
      |-> cap_ground_tied)
    else $error("capacitor ground not tied");
endmodule // sif_ctl_asserts

bind sif_ctl sif_ctl_asserts u_chk (.*);

//--- verif/sif_seq_model.sv
// Behavioural sequencer and front end facing the scan control block.
// Assumes the bench sets its levels by name; events last one pclk.
module sif_seq_model (
  // Clock
  input wire logic pclk,
  // Events
  output logic seq_start_pulse,
  output logic sequencer_stop_signal,
  output logic test_cycle_done,
  output logic [3:0] upper_flag_set,
  output logic [3:0] frontend_output_bits,
  output logic [2:0] flag_source_select,
  // Analogue requests
  output logic seq_dac_on,
  output logic seq_comp_on,
  output logic seq_gnd_connect,
  output logic [1:0] seq_channel,
  output logic test_cycle_active,
  output logic test_channel_id,
  // Front end result
  output logic comp_raw,
  output logic test_result_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {seq_start_pulse, sequencer_stop_signal, test_cycle_done, upper_flag_set} = '0;
    {frontend_output_bits, flag_source_select, seq_dac_on, seq_comp_on} = '0;
    {seq_gnd_connect, seq_channel, test_cycle_active, test_channel_id} = '0;
    {comp_raw, test_result_strobe} = '0;
  end
  // Event kinds: 0 run start, 1 test cycle end, 2 result ready
  task automatic pulse(input int k);
    @(posedge pclk);
    case (k)
      0: seq_start_pulse <= 1'b1;
      1: test_cycle_done <= 1'b1;
      default: test_result_strobe <= 1'b1;
    endcase
    @(posedge pclk);
    {seq_start_pulse, test_cycle_done, test_result_strobe} <= 3'h0;
  endtask
endmodule // sif_seq_model

//--- verif/tb.sv
// Self-checking bench for the scan interface control block.
// Assumes the sequencer model answers at once; APB master lives here.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] RA1 = sif_pkg::ADDR_CTL_ONE;
  localparam logic [7:0] RA2 = sif_pkg::ADDR_CTL_TWO;
  localparam logic [15:0] PWR_V [5] = '{16'h8000, 16'h4000, 16'h0100, 16'h0180, 16'h0040};
  localparam logic [4:0] PWR_X [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h3;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, module_enable, test_cycle_insert, dac_power, comp_power;
  logic comp_result, cap_ground_tied, mid_voltage_on, sample_hold_on, excitation_on, flag_irq;
  logic [1:0] comp_src_group, comp_src_index, seq_channel;
  logic seq_start_pulse, sequencer_stop_signal, test_cycle_done, seq_dac_on, seq_comp_on;
  logic seq_gnd_connect, test_cycle_active, test_channel_id, comp_raw, test_result_strobe;
  logic [3:0] upper_flag_set, frontend_output_bits;
  logic [2:0] flag_source_select;
  int num_errors = 0;
  int n_checks = 0;
  sif_ctl dut (.*);
  sif_seq_model m (.*);
  always #25 pclk = ~pclk;
  // ****************************************
  // Helpers
  // ****************************************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] v);
    n_checks++;
    if (v !== x) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, x, v);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask
  // Request held until the edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h00_0000, a};
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      num_errors++;
      give_verdict();
    end else begin
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [15:0] x);
    apb(1'b0, a, 16'h0000);
    chk(nm, {16'h0000, x}, q);
  endtask
  function automatic logic [4:0] pw();
    return {dac_power, comp_power, mid_voltage_on, sample_hold_on, excitation_on};
  endfunction
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd("ctl_one", RA1, 16'h0000);
    rd("ctl_two", RA2, 16'h0000);
    apb(1'b1, 8'h08, 16'hFFFF);
    chk("err_wr", 1, e);
    apb(1'b0, 8'h08, 16'h0000);
    chk("err_rd", 1, e);
    $display("end reset and map");
    apb(1'b1, RA1, 16'h0001);
    tick(2);
    chk("enable", 1, module_enable);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, RA2, PWR_V[i]);
      tick(2);
      chk("power", PWR_X[i], pw());
    end
    @(posedge pclk);
    m.seq_dac_on <= 1'b1;
    m.seq_comp_on <= 1'b1;
    m.comp_raw <= 1'b1;
    tick(2);
    chk("seq_power", 5'h19, pw());
    chk("cmp_plain", 1, comp_result);
    apb(1'b1, RA1, 16'h0000);
    tick(2);
    chk("off", 5'h00, pw());
    apb(1'b1, RA1, 16'h0001);
    apb(1'b1, RA2, 16'h2000);
    tick(2);
    chk("cmp_inv", 0, comp_result);
    chk("gnd_tied", 1, cap_ground_tied);
    apb(1'b1, RA2, 16'h0200);
    tick(2);
    chk("gnd_seq0", 0, cap_ground_tied);
    @(posedge pclk);
    m.seq_gnd_connect <= 1'b1;
    m.test_cycle_active <= 1'b1;
    tick(2);
    chk("gnd_seq1", 1, cap_ground_tied);
    $display("end power and steering");
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, RA2, 16'((i / 4) << 12 | (i % 4) << 4 | (3 - i % 4) << 2));
      m.test_channel_id <= 1'b1;
      tick(2);
      chk("src_t1", 4 * (i / 4) + i % 4, {comp_src_group, comp_src_index});
      @(posedge pclk);
      m.test_channel_id <= 1'b0;
      tick(2);
      chk("src_t0", 4 * (i / 4) + 3 - i % 4, {comp_src_group, comp_src_index});
    end
    apb(1'b1, RA2, 16'h1800);
    tick(2);
    chk("src_common", 2, comp_src_group);
    @(posedge pclk);
    m.test_cycle_active <= 1'b0;
    m.seq_channel <= 2'h1;
    apb(1'b1, RA2, 16'h1400);
    tick(2);
    chk("src_aux3", 4'h7, {comp_src_group, comp_src_index});
    apb(1'b1, RA2, 16'h1000);
    tick(2);
    chk("src_auxn", 4'h5, {comp_src_group, comp_src_index});
    $display("end input select");
    apb(1'b1, RA2, 16'h0000);
    m.test_channel_id <= 1'b1;
    m.pulse(2);
    rd("res_t1", RA2, 16'h0002);
    m.test_channel_id <= 1'b0;
    m.pulse(2);
    rd("res_t0", RA2, 16'h0003);
    @(posedge pclk);
    m.flag_source_select <= 3'h2;
    m.sequencer_stop_signal <= 1'b1;
    m.pulse(0);
    m.frontend_output_bits <= 4'h2;
    m.upper_flag_set <= 4'hF;
    @(posedge pclk);
    m.upper_flag_set <= 4'h0;
    tick(2);
    rd("flags_set", RA1, 16'h01FD);
    apb(1'b1, RA1, 16'h0001);
    tick(3);
    rd("flags_clr", RA1, 16'h0001);
    @(posedge pclk);
    m.flag_source_select <= 3'h3;
    m.frontend_output_bits <= 4'h0;
    tick(2);
    rd("flag_fall", RA1, 16'h0005);
    pstrb <= 4'h1;
    apb(1'b1, RA1, 16'h0001);
    pstrb <= 4'h3;
    rd("lane_lo", RA1, 16'h0005);
    apb(1'b1, RA1, 16'h0205);
    tick(3);
    chk("irq_on", 1, flag_irq);
    apb(1'b1, RA1, 16'h0005);
    tick(3);
    chk("irq_off", 0, flag_irq);
    $display("end flags");
    apb(1'b1, RA1, 16'h0003);
    tick(2);
    chk("ins_on", 1, test_cycle_insert);
    m.pulse(1);
    tick(2);
    chk("ins_off", 0, test_cycle_insert);
    rd("ins_bit", RA1, 16'h0001);
    $display("end test insert");
    give_verdict();
  end
endmodule // tb
